// *** src/vdec_cfg_pkg.sv ***
// package: register offsets, field layouts and reset values of the decoder configuration bank
package vdec_cfg_pkg;
   localparam int unsigned DW = 12;
   // register indices; the printed sub-addresses are not all multiples of four
   localparam logic [8:0] IDX_INPUT_SELECT   = 9'h021;
   localparam logic [8:0] IDX_START_POS      = 9'h022;
   localparam logic [8:0] IDX_LUMA_DELAY     = 9'h023;
   localparam logic [8:0] IDX_CIP_MATCH      = 9'h027;
   localparam logic [8:0] IDX_COMB_CTRL      = 9'h028;
   localparam logic [8:0] IDX_HELPER_DELAY   = 9'h029;
   localparam logic [8:0] IDX_GFX_SCAN       = 9'h02f;
   localparam logic [8:0] IDX_SATURATION     = 9'h030;
   localparam logic [8:0] IDX_KILL_LEVEL     = 9'h039;
   localparam logic [8:0] IDX_KILL_HYST      = 9'h03a;
   localparam logic [8:0] IDX_COMB_TEST      = 9'h055;
   localparam logic [8:0] IDX_HUE            = 9'h0dc;
   localparam logic [8:0] IDX_HELPER_AUTO    = 9'h16c;
   localparam logic [8:0] IDX_GAIN_SEL       = 9'h17a;
   localparam logic [8:0] IDX_HELPER_MULT    = 9'h17d;
   // own control registers
   localparam logic [8:0] IDX_STD_SELECT     = 9'h020;
   localparam logic [8:0] IDX_SCALER_MODE    = 9'h040;
   localparam logic [8:0] IDX_COMPLETE_ACK   = 9'h041;
   localparam int unsigned IDX_W = 9;
   localparam int unsigned BYTE_SHIFT = 2;

   // reset values
   localparam logic [11:0] RST_INPUT_SELECT = 12'h444;
   localparam logic [11:0] RST_START_POS    = 12'h000;
   localparam logic [11:0] RST_LUMA_DELAY   = 12'h000;
   localparam logic [11:0] RST_CIP_MATCH    = 12'h009;
   localparam logic [11:0] RST_COMB_CTRL    = 12'h0e7;
   localparam logic [11:0] RST_HELPER_DELAY = 12'h000;
   localparam logic [11:0] RST_GFX_SCAN     = 12'h000;
   localparam logic [11:0] RST_SATURATION   = 12'h816;
   localparam logic [11:0] RST_KILL_LEVEL   = 12'h019;
   localparam logic [11:0] RST_KILL_HYST    = 12'h005;
   localparam logic [11:0] RST_COMB_TEST    = 12'h000;
   localparam logic [11:0] RST_HUE          = 12'h000;
   localparam logic [11:0] RST_HELPER_AUTO  = 12'h000;
   localparam logic [11:0] RST_GAIN_SEL     = 12'h637;
   localparam logic [11:0] RST_HELPER_MULT  = 12'h500;
   localparam logic [11:0] RST_STD_SELECT   = 12'h000;

   // field positions and masks
   localparam int unsigned BIT_DONE        = 11;
   localparam int unsigned BIT_NOTCH_KIND  = 7;
   localparam int unsigned BIT_LOWPASS     = 8;
   localparam int unsigned BIT_GFX_ENABLE  = 10;
   localparam int unsigned BIT_GAIN_FUNC   = 11;
   localparam int unsigned BIT_DC_REJECT   = 2;
   localparam logic [11:0] MASK_LUMA_DELAY = 12'hfc0;
   localparam logic [11:0] MASK_CIP_MATCH  = 12'hfc0;
   localparam logic [11:0] MASK_COMB_TEST  = 12'h004;
   localparam logic [11:0] MASK_GFX_SCAN   = 12'hc03;
   localparam logic [11:0] SAT_RESERVED    = 12'hfff;
   localparam logic [11:0] SAT_MAX         = 12'hffe;
   localparam logic [1:0]  AUTO_ENABLE     = 2'h1;
   localparam logic [11:0] ZERO12          = 12'h000;
   localparam logic [2:0]  INIT_CYCLES     = 3'h4;

   // live settings handed to the video datapath
   typedef struct packed {
      logic        secam_notch_kind;
      logic        luma_lowpass_enable;
      logic [1:0]  input_mux;
      logic        chroma_input;
      logic [1:0]  if_comp;
      logic [1:0]  chroma_bw;
      logic [11:0] active_start_position;
      logic [5:0]  luma_delay_adjust;
      logic [5:0]  cip_delay;
      logic [11:0] helper_line_delay;
      logic        helper_delay_active;
      logic [1:0]  graphics_scan_rate;
      logic        graphics_enable;
      logic [1:0]  comb_notch_select;
      logic [1:0]  diag_dot_reduce;
      logic [1:0]  horiz_difference_gain;
      logic [1:0]  vert_difference_gain;
      logic [3:0]  vertical_peaking_gain;
      logic        peaking_dc_reject_enable;
      logic [11:0] chroma_saturation;
      logic        gain_function_select;
      logic [10:0] helper_gain;
      logic [10:0] chroma_atten;
      logic [3:0]  mult_exponent;
      logic [6:0]  mult_mantissa;
      logic [10:0] colour_kill_level;
      logic        colour_kill_enable;
      logic        helper_auto_enable;
      logic [9:0]  helper_auto_fields;
      logic [11:0] hue_angle;
      logic        hue_active;
   } vdec_ctrl_t;
endpackage

// *** src/cfg_reg.sv ***
// one config word with reset value and writable-bit mask
`timescale 1ns/100ps
module cfg_reg #(
   parameter logic [11:0] RESET_VAL = 12'h000,
   parameter logic [11:0] WMASK     = 12'hfff
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        we,
   input  wire logic [11:0] wdata,
   output logic      [11:0] q
);
   logic [11:0] q_ff;
   wire  [11:0] nxt_q = we ? (wdata & WMASK) : q_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) q_ff <= RESET_VAL;
      else          q_ff <= nxt_q;
   end
   assign q = q_ff;
endmodule

// *** src/video_decoder_config_regs.sv ***
// top: apb register bank and live settings of the video decoder configuration
`timescale 1ns/100ps
module video_decoder_config_regs
   import vdec_cfg_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic                    helper_mode,
   input  wire logic                    ntsc_mode,
   output logic                         pready,
   output logic      [31:0]             prdata,
   output logic                         pslverr,
   output vdec_cfg_pkg::vdec_ctrl_t     ctrl,
   output logic                         std_init_busy
);
   import vdec_cfg_pkg::*;

   //****************************************
   // bus decode
   //****************************************
   logic            pready_ff;
   logic [31:0]     prdata_ff;
   logic            pslverr_ff;
   wire             acc      = psel & penable;
   wire             wr       = acc & pwrite & pready_ff;
   wire [IDX_W-1:0] idx      = paddr[IDX_W+BYTE_SHIFT-1:BYTE_SHIFT];
   wire             aligned  = (paddr[BYTE_SHIFT-1:0] == 2'h0) & (paddr[11] == 1'b0);
   wire [11:0]      wd       = pwdata[11:0];

   wire hit_input_select  = aligned & (idx == IDX_INPUT_SELECT);
   wire hit_start  = aligned & (idx == IDX_START_POS);
   wire hit_luma   = aligned & (idx == IDX_LUMA_DELAY);
   wire hit_cip    = aligned & (idx == IDX_CIP_MATCH);
   wire hit_comb   = aligned & (idx == IDX_COMB_CTRL);
   wire hit_hdly   = aligned & (idx == IDX_HELPER_DELAY);
   wire hit_gfx    = aligned & (idx == IDX_GFX_SCAN);
   wire hit_sat    = aligned & (idx == IDX_SATURATION);
   wire hit_kill   = aligned & (idx == IDX_KILL_LEVEL);
   wire hit_khy    = aligned & (idx == IDX_KILL_HYST);
   wire hit_ctst   = aligned & (idx == IDX_COMB_TEST);
   wire hit_hue    = aligned & (idx == IDX_HUE);
   wire hit_hauto  = aligned & (idx == IDX_HELPER_AUTO);
   wire hit_gain   = aligned & (idx == IDX_GAIN_SEL);
   wire hit_mult   = aligned & (idx == IDX_HELPER_MULT);
   wire hit_std    = aligned & (idx == IDX_STD_SELECT);
   wire hit_scm    = aligned & (idx == IDX_SCALER_MODE);
   wire hit_ack    = aligned & (idx == IDX_COMPLETE_ACK);
   wire hit_any    = hit_input_select | hit_start | hit_luma | hit_cip | hit_comb | hit_hdly
                   | hit_gfx | hit_sat | hit_kill | hit_khy | hit_ctst | hit_hue
                   | hit_hauto | hit_gain | hit_mult | hit_std | hit_scm | hit_ack;

   // reserved saturation code is refused, register keeps old value
   wire sat_bad    = (wd == SAT_RESERVED);

   //****************************************
   // plain storage
   //****************************************
   logic [11:0] r_start, r_luma, r_cip, r_comb, r_hdly, r_sat, r_kill, r_khy;
   logic [11:0] r_ctst, r_hue, r_hauto, r_gain, r_mult, r_std, r_scm;

   cfg_reg #(.RESET_VAL(RST_START_POS), .WMASK(12'hfff)) u_start (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_start), .wdata(wd), .q(r_start));
   cfg_reg #(.RESET_VAL(RST_LUMA_DELAY), .WMASK(MASK_LUMA_DELAY)) u_luma (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_luma), .wdata(wd), .q(r_luma));
   cfg_reg #(.RESET_VAL(RST_CIP_MATCH), .WMASK(12'hfff)) u_cip (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_cip), .wdata(wd), .q(r_cip));
   cfg_reg #(.RESET_VAL(RST_COMB_CTRL), .WMASK(12'hfff)) u_comb (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_comb), .wdata(wd), .q(r_comb));
   cfg_reg #(.RESET_VAL(RST_HELPER_DELAY), .WMASK(12'hfff)) u_hdly (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_hdly), .wdata(wd), .q(r_hdly));
   cfg_reg #(.RESET_VAL(RST_SATURATION), .WMASK(12'hfff)) u_sat (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_sat & !sat_bad), .wdata(wd), .q(r_sat));
   cfg_reg #(.RESET_VAL(RST_KILL_LEVEL), .WMASK(12'hfff)) u_kill (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_kill), .wdata(wd), .q(r_kill));
   cfg_reg #(.RESET_VAL(RST_KILL_HYST), .WMASK(12'hfff)) u_khy (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_khy), .wdata(wd), .q(r_khy));
   cfg_reg #(.RESET_VAL(RST_COMB_TEST), .WMASK(MASK_COMB_TEST)) u_ctst (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_ctst), .wdata(wd), .q(r_ctst));
   cfg_reg #(.RESET_VAL(RST_HUE), .WMASK(12'hfff)) u_hue (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_hue), .wdata(wd), .q(r_hue));
   cfg_reg #(.RESET_VAL(RST_HELPER_AUTO), .WMASK(12'hfff)) u_hauto (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_hauto), .wdata(wd), .q(r_hauto));
   cfg_reg #(.RESET_VAL(RST_GAIN_SEL), .WMASK(12'hfff)) u_gain (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_gain), .wdata(wd), .q(r_gain));
   cfg_reg #(.RESET_VAL(RST_HELPER_MULT), .WMASK(12'hfff)) u_mult (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_mult), .wdata(wd), .q(r_mult));
   cfg_reg #(.RESET_VAL(RST_STD_SELECT), .WMASK(12'hfff)) u_std (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_std), .wdata(wd), .q(r_std));
   cfg_reg #(.RESET_VAL(RST_STD_SELECT), .WMASK(12'hfff)) u_scm (
      .pclk(pclk), .presetn(presetn), .we(wr & hit_scm), .wdata(wd), .q(r_scm));

   //****************************************
   // input select and standard init
   //****************************************
   typedef enum logic [1:0] {INIT_IDLE, INIT_RUN} init_state_t;
   init_state_t state_ff, nxt_state;
   logic [2:0]  init_cnt_ff;
   logic [2:0]  nxt_init_cnt;
   logic [10:0] input_select_ff;
   logic        done_ff;
   logic        start_apply_ff;
   logic        busy_ff;

   wire input_select_wr  = wr & hit_input_select;
   // the standard setup is shared, so an input-select write or a standard write restarts it
   wire init_go   = input_select_wr | (wr & hit_std);
   wire init_last = (state_ff == INIT_RUN) & (init_cnt_ff == 3'h1);

   always_comb begin
      nxt_state    = state_ff;
      nxt_init_cnt = init_cnt_ff;
      case (state_ff)
         INIT_IDLE: begin
            if (init_go) begin
               nxt_state    = INIT_RUN;
               nxt_init_cnt = INIT_CYCLES;
            end
         end
         INIT_RUN: begin
            if (init_go) begin
               nxt_init_cnt = INIT_CYCLES;
            end else if (init_cnt_ff == 3'h1) begin
               nxt_state    = INIT_IDLE;
               nxt_init_cnt = 3'h0;
            end else begin
               nxt_init_cnt = init_cnt_ff - 3'h1;
            end
         end
         default: begin
            nxt_state    = INIT_IDLE;
            nxt_init_cnt = 3'h0;
         end
      endcase
   end

   // done flag: cleared by the write, set when setup completes; completion wins over ack
   wire nxt_done = (init_last & !init_go) ? 1'b1 :
                   (init_go | (wr & hit_ack)) ? 1'b0 : done_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff    <= INIT_IDLE;
         init_cnt_ff <= 3'h0;
         input_select_ff    <= RST_INPUT_SELECT[10:0];
         done_ff     <= 1'b0;
         busy_ff     <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         init_cnt_ff <= nxt_init_cnt;
         if (input_select_wr) input_select_ff <= wd[10:0];
         done_ff     <= nxt_done;
         busy_ff     <= (nxt_state == INIT_RUN);
      end
   end

   // start position is latched into the live setting only on these writes
   wire apply_start = wr & (hit_std | hit_scm);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) start_apply_ff <= 1'b0;
      else          start_apply_ff <= apply_start;
   end

   //****************************************
   // graphics scan register
   //****************************************
   logic [11:0] gfx_ff;
   // hardware clears bit 11 whenever enable is zero, including after a write
   wire [11:0] gfx_w   = wd & MASK_GFX_SCAN;
   wire [11:0] gfx_src = (wr & hit_gfx) ? gfx_w : gfx_ff;
   wire [11:0] nxt_gfx = gfx_src[BIT_GFX_ENABLE] ? gfx_src
                       : {1'b0, gfx_src[10:0]};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gfx_ff <= RST_GFX_SCAN;
      else          gfx_ff <= nxt_gfx;
   end

   //****************************************
   // live settings
   //****************************************
   vdec_ctrl_t nxt_ctrl;
   vdec_ctrl_t ctrl_ff;
   always_comb begin
      nxt_ctrl                          = ctrl_ff;
      nxt_ctrl.input_mux                = input_select_ff[1:0];
      nxt_ctrl.chroma_input             = input_select_ff[2];
      nxt_ctrl.if_comp                  = input_select_ff[4:3];
      nxt_ctrl.chroma_bw                = input_select_ff[6:5];
      nxt_ctrl.secam_notch_kind         = input_select_ff[BIT_NOTCH_KIND];
      nxt_ctrl.luma_lowpass_enable      = input_select_ff[BIT_LOWPASS];
      if (start_apply_ff) nxt_ctrl.active_start_position = r_start;
      nxt_ctrl.luma_delay_adjust        = r_luma[11:6];
      nxt_ctrl.cip_delay                = r_cip[11:6];
      nxt_ctrl.helper_line_delay        = r_hdly;
      nxt_ctrl.helper_delay_active      = helper_mode;
      nxt_ctrl.graphics_scan_rate       = gfx_ff[1:0];
      nxt_ctrl.graphics_enable          = gfx_ff[BIT_GFX_ENABLE];
      nxt_ctrl.comb_notch_select        = r_comb[1:0];
      nxt_ctrl.diag_dot_reduce          = r_comb[3:2];
      nxt_ctrl.horiz_difference_gain    = r_comb[5:4];
      nxt_ctrl.vert_difference_gain     = ~r_comb[7:6];
      nxt_ctrl.vertical_peaking_gain    = r_comb[11:8];
      nxt_ctrl.peaking_dc_reject_enable = r_ctst[BIT_DC_REJECT];
      nxt_ctrl.chroma_saturation        = r_sat;
      nxt_ctrl.gain_function_select     = r_gain[BIT_GAIN_FUNC];
      // unused function sees zero so only one gain path is live
      nxt_ctrl.helper_gain  = r_gain[BIT_GAIN_FUNC] ? 11'h000 : r_gain[10:0];
      nxt_ctrl.chroma_atten = r_gain[BIT_GAIN_FUNC] ? r_gain[10:0] : 11'h000;
      nxt_ctrl.mult_exponent            = r_mult[10:7];
      nxt_ctrl.mult_mantissa            = r_mult[6:0];
      nxt_ctrl.colour_kill_level        = r_kill[10:0];
      nxt_ctrl.colour_kill_enable       = (r_kill[10:0] != 11'h000);
      nxt_ctrl.helper_auto_enable       = (r_hauto != ZERO12)
                                        & (r_hauto[1:0] == AUTO_ENABLE);
      nxt_ctrl.helper_auto_fields       = r_hauto[11:2];
      nxt_ctrl.hue_angle                = r_hue;
      nxt_ctrl.hue_active               = ntsc_mode;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctrl_ff <= '0;
      else          ctrl_ff <= nxt_ctrl;
   end
   assign ctrl          = ctrl_ff;
   assign std_init_busy = busy_ff;

   //****************************************
   // read mux
   //****************************************
   wire [11:0] rd_word =
        hit_input_select ? {done_ff, input_select_ff} :
        hit_start ? r_start :
        hit_luma  ? r_luma  :
        hit_cip   ? r_cip   :
        hit_comb  ? r_comb  :
        hit_hdly  ? r_hdly  :
        hit_gfx   ? gfx_ff  :
        hit_sat   ? r_sat   :
        hit_kill  ? r_kill  :
        hit_khy   ? r_khy   :
        hit_ctst  ? r_ctst  :
        hit_hue   ? r_hue   :
        hit_hauto ? r_hauto :
        hit_gain  ? r_gain  :
        hit_mult  ? r_mult  :
        hit_std   ? r_std   :
        hit_scm   ? r_scm   : ZERO12;

   //****************************************
   // bus answer
   //****************************************
   // answer built in the setup cycle, so the access cycle needs no wait state
   wire setup_ph = psel & !penable;
   wire rd_err   = !hit_any | (pwrite & hit_sat & sat_bad);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= setup_ph;
         prdata_ff  <= setup_ph ? {20'h00000, rd_word} : 32'h00000000;
         pslverr_ff <= setup_ph & rd_err;
      end
   end
   assign pready  = pready_ff;
   assign prdata  = prdata_ff;
   assign pslverr = pslverr_ff;

   //****************************************
   // checks
   //****************************************
   AST_INIT_DONE: assert property (@(posedge pclk) disable iff (!presetn)
      (input_select_wr && state_ff == INIT_IDLE) |=> (state_ff == INIT_RUN) ##4 done_ff)
      else $error("input select write did not complete setup in time");
   AST_INIT_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
      init_go |=> std_init_busy)
      else $error("setup not busy after restart write");
   AST_NOTCH_KIND: assert property (@(posedge pclk) disable iff (!presetn)
      input_select_wr |-> ##2 (ctrl_ff.secam_notch_kind == input_select_ff[BIT_NOTCH_KIND]))
      else $error("notch kind not taken from input select");
   AST_LOWPASS: assert property (@(posedge pclk) disable iff (!presetn)
      input_select_wr |-> ##2 (ctrl_ff.luma_lowpass_enable == input_select_ff[BIT_LOWPASS]))
      else $error("lowpass enable not taken from input select");
   AST_SAT_ERR: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_ph && pwrite && hit_sat && sat_bad) |=> pslverr)
      else $error("reserved saturation write not flagged");
   AST_ATTEN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_gain && !wd[BIT_GAIN_FUNC]) |-> ##2 (ctrl_ff.chroma_atten == 11'h000))
      else $error("attenuation live while helper gain selected");
   AST_KILL_ON: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_kill && wd[10:0] != 11'h000) |-> ##2 ctrl_ff.colour_kill_enable)
      else $error("killer off at nonzero level");
   AST_AUTO_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_hauto && wd == ZERO12) |-> ##2 !ctrl_ff.helper_auto_enable)
      else $error("auto helper disable on at zero");
   AST_DONE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      input_select_wr |=> !done_ff)
      else $error("done bit not cleared by input select write");
   AST_START_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      (!$past(start_apply_ff) && $past(presetn)) |-> $stable(ctrl_ff.active_start_position))
      else $error("start position changed without standard or scaler write");
   AST_LUMA_RSV: assert property (@(posedge pclk) disable iff (!presetn)
      r_luma[5:0] == 6'h00)
      else $error("luma delay reserved bits not zero");
   AST_GFX_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      !gfx_ff[BIT_GFX_ENABLE] |-> !gfx_ff[11])
      else $error("graphics bit 11 set while disabled");
   AST_SAT_RSV: assert property (@(posedge pclk) disable iff (!presetn)
      r_sat != SAT_RESERVED)
      else $error("reserved saturation code stored");
   AST_GAIN_SEL: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_gain && wd[BIT_GAIN_FUNC]) |-> ##2 (ctrl_ff.helper_gain == 11'h000))
      else $error("helper gain live while attenuation selected");
   AST_KILL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_kill && wd[10:0] == 11'h000) |-> ##2 !ctrl_ff.colour_kill_enable)
      else $error("killer enabled at zero level");
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the decoder configuration register bank
`timescale 1ns/100ps
module testbench;
   import vdec_cfg_pkg::*;
   logic                 pclk;
   logic                 presetn;
   logic                 psel;
   logic                 penable;
   logic                 pwrite;
   logic [11:0]          paddr;
   logic [31:0]          pwdata;
   logic                 pready;
   logic [31:0]          prdata;
   logic                 pslverr;
   vdec_cfg_pkg::vdec_ctrl_t ctrl;
   logic                 std_init_busy;
   logic                 helper_mode;
   logic                 ntsc_mode;
   logic [31:0]          rdat;
   logic                 rerr;
   int                   mismatches = 0;
   int                   compares = 0;

   video_decoder_config_regs video_decoder_config_regs_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .helper_mode(helper_mode), .ntsc_mode(ntsc_mode),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .ctrl(ctrl),
      .std_init_busy(std_init_busy));

   // ****************
   // helpers
   // ****************
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [8:0] idx, input logic [11:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {1'b0, idx, 2'b00};
      pwdata  <= {20'h00000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         $display("Error pready expected 1 seen %b", pready);
         mismatches++;
         conclude();
      end
   endtask

   // ctrl follows storage by one edge
   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic reset_values();
      logic [8:0]  ix [8] = '{9'h021, 9'h027, 9'h028, 9'h030, 9'h039, 9'h03a, 9'h17a, 9'h17d};
      logic [11:0] rv [8] = '{12'h444, 12'h009, 12'h0e7, 12'h816, 12'h019, 12'h005,
                              12'h637, 12'h500};
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, ix[i], 12'h000);
         chk("reset value", {20'h00000, rv[i]}, rdat);
      end
      chk("vert diff gain", 32'h0, 32'(ctrl.vert_difference_gain));
      chk("notch select", 32'h3, 32'(ctrl.comb_notch_select));
   endtask

   task automatic input_select();
      logic [11:0] v [2] = '{12'h180, 12'h004};
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, 9'h021, v[i]);
         @(posedge pclk);
         #1;
         chk("busy", 32'h1, 32'(std_init_busy));
         apb(1'b0, 9'h021, 12'h000);
         chk("done early", {20'h00000, v[i]}, rdat);
         repeat (4) @(posedge pclk);
         apb(1'b0, 9'h021, 12'h000);
         chk("done late", {20'h00000, v[i] | 12'h800}, rdat);
         chk("busy off", 32'h0, 32'(std_init_busy));
         chk("notch kind", 32'(v[i][7]), 32'(ctrl.secam_notch_kind));
         chk("lowpass", 32'(v[i][8]), 32'(ctrl.luma_lowpass_enable));
         apb(1'b1, 9'h041, 12'h000);
         apb(1'b0, 9'h021, 12'h000);
         chk("done ack", {20'h00000, v[i]}, rdat);
      end
   endtask

   task automatic start_position();
      apb(1'b1, 9'h022, 12'h123);
      settle();
      chk("start held", 32'h0, 32'(ctrl.active_start_position));
      apb(1'b1, 9'h040, 12'h000);
      settle();
      chk("start applied", 32'h123, 32'(ctrl.active_start_position));
      apb(1'b1, 9'h022, 12'h456);
      apb(1'b1, 9'h020, 12'h000);
      settle();
      chk("start on std", 32'h456, 32'(ctrl.active_start_position));
   endtask

   task automatic fields();
      apb(1'b1, 9'h023, 12'hfff);
      apb(1'b0, 9'h023, 12'h000);
      chk("luma delay", 32'hfc0, rdat);
      apb(1'b1, 9'h055, 12'hfff);
      apb(1'b0, 9'h055, 12'h000);
      chk("comb test", 32'h004, rdat);
      apb(1'b1, 9'h028, 12'hf04);
      settle();
      chk("dc reject", 32'h1, 32'(ctrl.peaking_dc_reject_enable));
      chk("peaking", 32'hf, 32'(ctrl.vertical_peaking_gain));
      chk("vdg inverted", 32'h3, 32'(ctrl.vert_difference_gain));
      chk("hdg", 32'h0, 32'(ctrl.horiz_difference_gain));
      chk("notch flat", 32'h0, 32'(ctrl.comb_notch_select));
      chk("luma ctrl", 32'h3f, 32'(ctrl.luma_delay_adjust));
      apb(1'b1, 9'h02f, 12'hc01);
      settle();
      chk("scan rate", 32'h1, 32'(ctrl.graphics_scan_rate));
      chk("gfx enable", 32'h1, 32'(ctrl.graphics_enable));
      apb(1'b1, 9'h02f, 12'h802);
      apb(1'b0, 9'h02f, 12'h000);
      chk("gfx bit cleared", 32'h002, rdat);
   endtask

   task automatic gain_and_refusal();
      apb(1'b1, 9'h17a, 12'hfff);
      settle();
      chk("atten", 32'h7ff, 32'(ctrl.chroma_atten));
      chk("helper off", 32'h0, 32'(ctrl.helper_gain));
      apb(1'b1, 9'h17a, 12'h637);
      settle();
      chk("helper gain", 32'h637, 32'(ctrl.helper_gain));
      chk("atten off", 32'h0, 32'(ctrl.chroma_atten));
      apb(1'b1, 9'h030, 12'hfff);
      chk("sat refused", 32'h1, 32'(rerr));
      apb(1'b0, 9'h030, 12'h000);
      chk("sat kept", 32'h816, rdat);
      apb(1'b1, 9'h030, 12'hffe);
      apb(1'b0, 9'h030, 12'h000);
      chk("sat max", 32'hffe, rdat);
      apb(1'b0, 9'h1ff, 12'h000);
      chk("unmapped err", 32'h1, 32'(rerr));
      chk("unmapped data", 32'h0, rdat);
   endtask

   task automatic modes_and_levels();
      chk("kill reset", 32'h1, 32'(ctrl.colour_kill_enable));
      chk("helper gate", 32'h0, 32'(ctrl.helper_delay_active));
      chk("hue gate", 32'h0, 32'(ctrl.hue_active));
      helper_mode <= 1'b1;
      ntsc_mode   <= 1'b1;
      apb(1'b1, 9'h029, 12'hfe0);
      apb(1'b1, 9'h0dc, 12'he00);
      apb(1'b1, 9'h027, 12'h240);
      apb(1'b1, 9'h17d, 12'h285);
      apb(1'b1, 9'h039, 12'h000);
      apb(1'b1, 9'h16c, 12'h0a5);
      settle();
      chk("helper on", 32'h1, 32'(ctrl.helper_delay_active));
      chk("helper delay", 32'hfe0, 32'(ctrl.helper_line_delay));
      chk("hue on", 32'h1, 32'(ctrl.hue_active));
      chk("hue angle", 32'he00, 32'(ctrl.hue_angle));
      chk("cip matched", 32'h9, 32'(ctrl.cip_delay));
      chk("mult exp", 32'h5, 32'(ctrl.mult_exponent));
      chk("mult mant", 32'h5, 32'(ctrl.mult_mantissa));
      chk("kill off", 32'h0, 32'(ctrl.colour_kill_enable));
      chk("auto on", 32'h1, 32'(ctrl.helper_auto_enable));
      chk("auto fields", 32'h29, 32'(ctrl.helper_auto_fields));
      apb(1'b1, 9'h16c, 12'h000);
      settle();
      chk("auto off", 32'h0, 32'(ctrl.helper_auto_enable));
   endtask

   // ****************
   // main sequence
   // ****************
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h00000000;
      helper_mode = 1'b0;
      ntsc_mode   = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      reset_values();
      input_select();
      start_position();
      fields();
      gain_and_refusal();
      modes_and_levels();
      conclude();
   end
endmodule
